// ---- inc/mss_pkg.sv ----
// Constants and types for the multi-mode serial channel.
// Assumes an APB slave front end with 32-bit data and a 200 MHz clock.
package mss_pkg;
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_CTRL_A = 8'h04;
  localparam logic [7:0] ADDR_CTRL_B = 8'h08;
  localparam logic [7:0] ADDR_BRG = 8'h0C;
  localparam logic [7:0] ADDR_TXB = 8'h10;
  localparam logic [7:0] ADDR_RXB = 8'h14;
  localparam logic [7:0] ADDR_SMR4 = 8'h18;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h1C;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h20;
  // Mode field values
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_SYNC = 3'h1;
  localparam logic [2:0] MODE_UART7 = 3'h4;
  localparam logic [2:0] MODE_UART8 = 3'h5;
  localparam logic [2:0] MODE_UART9 = 3'h6;
  // channel_control_a fields
  localparam int CA_CLK_LO = 0;
  localparam int CA_CLK_HI = 1;
  localparam int CA_EXT_CLK = 3;
  localparam int CA_POL = 6;
  // channel_control_b fields
  localparam int CB_TE = 0;
  localparam int CB_TI = 1;
  localparam int CB_RE = 2;
  localparam int CB_RI = 3;
  // rx_buffer overrun bit
  localparam int RB_OVR = 12;
  // special_mode_control_four fields
  localparam int S4_STA = 0;
  localparam int S4_RSTA = 1;
  localparam int S4_STP = 2;
  localparam int S4_SEL = 3;
  // Interrupt status bits
  localparam int IRQ_TX = 0;
  localparam int IRQ_RX = 1;
  localparam int IRQ_OVR = 2;
  localparam int IRQ_W = 3;
  localparam int SEVENTH_BIT = 6;
  localparam logic [7:0] BRG_RST = 8'h00;
  localparam logic [7:0] BRG_WRAP = 8'hFF;
  typedef enum logic [1:0] {
    SH_IDLE = 2'b00,
    SH_LOW = 2'b01,
    SH_HIGH = 2'b10
  } mss_shift_e;
endpackage : mss_pkg

// ---- hdl/mss_brg.sv ----
// Bit-rate divider: count source prescale, then reload counter.
// Assumes one clock; outputs a one-cycle enable per divided tick.
`timescale 1ns/1ps
module mss_brg (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [1:0] src_sel_i,
  input wire logic load_i,
  input wire logic [7:0] div_i,
  output logic tick_o
);
  logic [5:0] pre_r;
  logic [7:0] cnt_r;
  logic src_en;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pre_r <= 6'h00;
    end else begin
      pre_r <= pre_r + 6'h01;
    end
  end

  always_comb begin
    case (src_sel_i)
      2'b00: src_en = 1'b1;
      2'b01: src_en = (pre_r[2:0] == 3'h7);
      2'b10: src_en = (pre_r == 6'h3F);
      default: src_en = (pre_r[4:0] == 5'h1F);
    endcase
  end

  // Loading 00h: a source edge in the same cycle wraps to FFh first
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_r <= mss_pkg::BRG_RST;
      tick_o <= 1'b0;
    end else if (load_i) begin
      cnt_r <= (src_en && div_i == 8'h00) ? mss_pkg::BRG_WRAP : div_i;
      tick_o <= 1'b0;
    end else if (src_en) begin
      tick_o <= (cnt_r == 8'h00);
      cnt_r <= (cnt_r == 8'h00) ? div_i : cnt_r - 8'h01;
    end else begin
      tick_o <= 1'b0;
    end
  end
endmodule : mss_brg

// ---- hdl/mss_sync2.sv ----
// Two-flop synchroniser for pin inputs.
// Assumes the input is asynchronous to clk_i.
`timescale 1ns/1ps
module mss_sync2 (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic rst_val_i,
  input wire logic d_i,
  output logic q_o
);
  logic meta_r;
  logic rst_q_r;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_r <= 1'b1;
      q_o <= 1'b1;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end

  // rst_val_i unused for async reset; kept constant-high idle
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_q_r <= 1'b0;
    end else begin
      rst_q_r <= rst_val_i;
    end
  end
endmodule : mss_sync2

// ---- hdl/mss_top.sv ----
// Multi-mode serial channel: APB registers, sync and UART shifter, I2C conditions.
// Assumes APB master on CLK_I; serial pins are asynchronous.
`timescale 1ns/1ps
module mss_top (
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire logic SCLK_I,
  output logic SCLK_O,
  output logic SCLK_OE_N_O,
  input wire logic RXD_I,
  output logic TXD_O,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_N_O,
  output logic IRQ_O
);
  logic [2:0] mode_r;
  logic [7:0] ctrl_a_r;
  logic te_r;
  logic re_r;
  logic [7:0] brg_r;
  logic brg_load_r;
  logic [8:0] txb_r;
  logic tx_full_r;
  logic [8:0] rxb_r;
  logic rx_full_r;
  logic ovr_r;
  logic [3:0] smr4_r;
  logic [mss_pkg::IRQ_W-1:0] ist_r;
  logic [mss_pkg::IRQ_W-1:0] imask_r;
  logic tick;
  logic sclk_s;
  logic rxd_s;
  logic sda_s;
  logic sclk_d_r;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  logic pol;
  logic ext_clk;
  logic [3:0] nbits;
  mss_pkg::mss_shift_e sh_r;
  logic [9:0] tsh_r;
  logic [8:0] rsh_r;
  logic [3:0] bit_r;
  logic busy_r;
  logic int_clk_r;
  logic ev_tx;
  logic ev_rx;
  logic ev_ovr;
  logic shift_edge;
  logic sample_edge;
  logic ext_rise;
  logic ext_fall;
  logic [3:0] osc_r;

  assign wr = PSEL_I && PENABLE_I && PWRITE_I;
  assign rd = PSEL_I && PENABLE_I && !PWRITE_I;
  assign pol = ctrl_a_r[mss_pkg::CA_POL];
  assign ext_clk = ctrl_a_r[mss_pkg::CA_EXT_CLK];

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and divider
  mss_sync2 u_sync_sclk (
    .clk_i(CLK_I), .nrst_i(NRST_I), .rst_val_i(1'b1), .d_i(SCLK_I), .q_o(sclk_s)
  );
  mss_sync2 u_sync_rxd (
    .clk_i(CLK_I), .nrst_i(NRST_I), .rst_val_i(1'b1), .d_i(RXD_I), .q_o(rxd_s)
  );
  mss_sync2 u_sync_sda (
    .clk_i(CLK_I), .nrst_i(NRST_I), .rst_val_i(1'b1), .d_i(SDA_I), .q_o(sda_s)
  );

  mss_brg u_brg (
    .clk_i(CLK_I),
    .nrst_i(NRST_I),
    .src_sel_i({ctrl_a_r[mss_pkg::CA_CLK_HI], ctrl_a_r[mss_pkg::CA_CLK_LO]}),
    .load_i(brg_load_r),
    .div_i(brg_r),
    .tick_o(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // APB slave
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      mode_r <= mss_pkg::MODE_OFF;
      ctrl_a_r <= 8'h00;
      te_r <= 1'b0;
      re_r <= 1'b0;
      brg_r <= mss_pkg::BRG_RST;
      brg_load_r <= 1'b0;
      smr4_r <= 4'h0;
      imask_r <= '0;
    end else begin
      brg_load_r <= 1'b0;
      if (wr) begin
        case (PADDR_I)
          mss_pkg::ADDR_MODE: mode_r <= PWDATA_I[2:0];
          mss_pkg::ADDR_CTRL_A: ctrl_a_r <= PWDATA_I[7:0];
          mss_pkg::ADDR_CTRL_B: begin
            te_r <= PWDATA_I[mss_pkg::CB_TE];
            re_r <= PWDATA_I[mss_pkg::CB_RE];
          end
          mss_pkg::ADDR_BRG: begin
            brg_r <= PWDATA_I[7:0];
            brg_load_r <= 1'b1;
          end
          mss_pkg::ADDR_SMR4: smr4_r <= PWDATA_I[3:0];
          mss_pkg::ADDR_IRQ_MASK: imask_r <= PWDATA_I[mss_pkg::IRQ_W-1:0];
          default: ;
        endcase
      end else if (smr4_r[2:0] != 3'h0 && !smr4_r[mss_pkg::S4_SEL] && tick) begin
        smr4_r[2:0] <= 3'h0;
      end
    end
  end

  always_comb begin
    case (PADDR_I)
      mss_pkg::ADDR_MODE: rdata = {29'h0, mode_r};
      mss_pkg::ADDR_CTRL_A: rdata = {24'h0, ctrl_a_r};
      mss_pkg::ADDR_CTRL_B: rdata = {28'h0, rx_full_r, re_r, !tx_full_r, te_r};
      mss_pkg::ADDR_BRG: rdata = {24'h0, brg_r};
      mss_pkg::ADDR_TXB: rdata = {23'h0, txb_r};
      mss_pkg::ADDR_RXB: rdata = {19'h0, ovr_r, 3'h0, rxb_r};
      mss_pkg::ADDR_SMR4: rdata = {28'h0, smr4_r};
      mss_pkg::ADDR_IRQ_STAT: rdata = {29'h0, ist_r};
      mss_pkg::ADDR_IRQ_MASK: rdata = {29'h0, imask_r};
      default: rdata = 32'h0;
    endcase
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      PRDATA_O <= 32'h0;
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
    end else begin
      PREADY_O <= PSEL_I && !PENABLE_I;
      PSLVERR_O <= PSEL_I && !PENABLE_I && (PADDR_I > mss_pkg::ADDR_IRQ_MASK || PADDR_I[1:0] != 2'b00);
      if (PSEL_I && !PENABLE_I) begin
        PRDATA_O <= rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shift clock edges
  always_comb begin
    case (mode_r)
      mss_pkg::MODE_UART7: nbits = 4'd7;
      mss_pkg::MODE_UART9: nbits = 4'd9;
      default: nbits = 4'd8;
    endcase
  end

  // Internal clock idles high; polarity flips the active edges
  assign ext_rise = sclk_s && !sclk_d_r;
  assign ext_fall = !sclk_s && sclk_d_r;
  assign shift_edge = ext_clk ? (pol ? ext_rise : ext_fall)
                              : (tick && int_clk_r && busy_r);
  assign sample_edge = ext_clk ? (pol ? ext_fall : ext_rise)
                               : (tick && !int_clk_r);

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      sclk_d_r <= 1'b1;
    end else begin
      sclk_d_r <= sclk_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit buffer and shifter; receive only samples during transmit frames
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      txb_r <= 9'h000;
      tx_full_r <= 1'b0;
      tsh_r <= 10'h3FF;
      bit_r <= 4'h0;
      busy_r <= 1'b0;
      int_clk_r <= 1'b1;
      sh_r <= mss_pkg::SH_IDLE;
      osc_r <= 4'h0;
    end else if (mode_r == mss_pkg::MODE_OFF || !te_r) begin
      tx_full_r <= (mode_r == mss_pkg::MODE_OFF) ? 1'b0 : tx_full_r;
      busy_r <= 1'b0;
      int_clk_r <= 1'b1;
      sh_r <= mss_pkg::SH_IDLE;
      tsh_r <= 10'h3FF;
      bit_r <= 4'h0;
      if (wr && PADDR_I == mss_pkg::ADDR_TXB && mode_r != mss_pkg::MODE_OFF) begin
        txb_r <= PWDATA_I[8:0];
        tx_full_r <= 1'b1;
      end
    end else begin
      if (wr && PADDR_I == mss_pkg::ADDR_TXB) begin
        txb_r <= PWDATA_I[8:0];
        tx_full_r <= 1'b1;
      end
      if (!busy_r && tx_full_r && (!ext_clk || sclk_s == !pol)) begin
        // External clock may only start once idle at rest level
        tsh_r <= {txb_r, 1'b0};
        busy_r <= 1'b1;
        bit_r <= 4'h0;
        tx_full_r <= 1'b0;
        sh_r <= mss_pkg::SH_LOW;
      end else if (busy_r) begin
        if (!ext_clk && tick) begin
          int_clk_r <= !int_clk_r;
        end
        if (shift_edge) begin
          tsh_r <= {1'b1, tsh_r[9:1]};
          sh_r <= mss_pkg::SH_HIGH;
        end
        if (sample_edge) begin
          bit_r <= bit_r + 4'h1;
          osc_r <= osc_r + 4'h1;
          if (bit_r == nbits - 4'h1) begin
            busy_r <= 1'b0;
            int_clk_r <= 1'b1;
            sh_r <= mss_pkg::SH_IDLE;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive shifter, buffer and overrun
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rsh_r <= 9'h000;
      rxb_r <= 9'h000;
      rx_full_r <= 1'b0;
      ovr_r <= 1'b0;
    end else if (mode_r == mss_pkg::MODE_OFF || !re_r) begin
      rx_full_r <= (mode_r == mss_pkg::MODE_OFF) ? 1'b0 : rx_full_r;
      ovr_r <= (mode_r == mss_pkg::MODE_OFF) ? 1'b0 : ovr_r;
    end else begin
      if (rd && PADDR_I == mss_pkg::ADDR_RXB && PREADY_O) begin
        rx_full_r <= 1'b0;
        ovr_r <= 1'b0;
      end
      if (busy_r && sample_edge) begin
        rsh_r <= {rxd_s, rsh_r[8:1]};
        if (bit_r == 4'(mss_pkg::SEVENTH_BIT) && rx_full_r) begin
          ovr_r <= 1'b1;
        end
        if (bit_r == nbits - 4'h1) begin
          rxb_r <= {rxd_s, rsh_r[8:1]} >> (4'd9 - nbits);
          rx_full_r <= 1'b1;
        end
      end
    end
  end

  assign ev_tx = !busy_r && tx_full_r && te_r && mode_r != mss_pkg::MODE_OFF;
  assign ev_ovr = busy_r && sample_edge && re_r && rx_full_r
                  && bit_r == 4'(mss_pkg::SEVENTH_BIT);
  // Receive request only when the receive buffer is empty and no overrun is pending
  assign ev_rx = busy_r && sample_edge && re_r && bit_r == nbits - 4'h1
                 && !ovr_r && !(rx_full_r);

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, write one to clear, set wins
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      ist_r <= '0;
    end else begin
      for (int k = 0; k < mss_pkg::IRQ_W; k++) begin
        if ((k == mss_pkg::IRQ_TX && ev_tx) || (k == mss_pkg::IRQ_RX && ev_rx)
            || (k == mss_pkg::IRQ_OVR && ev_ovr)) begin
          ist_r[k] <= 1'b1;
        end else if (wr && PADDR_I == mss_pkg::ADDR_IRQ_STAT && PWDATA_I[k]) begin
          ist_r[k] <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output pins
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      IRQ_O <= 1'b0;
      TXD_O <= 1'b1;
      SCLK_O <= 1'b1;
      SCLK_OE_N_O <= 1'b1;
      SDA_O <= 1'b1;
      SDA_OE_N_O <= 1'b1;
    end else begin
      IRQ_O <= |(ist_r & imask_r);
      TXD_O <= busy_r ? tsh_r[0] : 1'b1;
      SCLK_O <= int_clk_r ^ pol;
      SCLK_OE_N_O <= ext_clk || mode_r == mss_pkg::MODE_OFF;
      // Condition generation only when select is cleared
      if (!smr4_r[mss_pkg::S4_SEL]) begin
        if (smr4_r[mss_pkg::S4_STA] || smr4_r[mss_pkg::S4_RSTA]) begin
          SDA_O <= 1'b0;
          SDA_OE_N_O <= 1'b0;
        end else if (smr4_r[mss_pkg::S4_STP]) begin
          SDA_O <= 1'b1;
          SDA_OE_N_O <= 1'b1;
        end
      end else begin
        SDA_O <= tsh_r[0];
        SDA_OE_N_O <= tsh_r[0] || !busy_r;
      end
    end
  end
endmodule : mss_top

// ---- tb/mss_remote.sv ----
// Far-side serial device for the channel bench.
// Assumes the bench wires it to the channel pins on the same clock.
`timescale 1ns/1ps
module mss_remote (
  input wire logic clk_i,
  input wire logic txd_i,
  input wire logic sda_i,
  input wire logic sda_oe_n_i,
  output logic rxd_o,
  output logic sclk_o,
  output logic sda_o
);
  logic rxd_r = 1'b1;
  //////////////////////////////////////////////
  // Line echoes our transmit back one clock late
  always @(posedge clk_i) begin
    rxd_r <= txd_i;
  end
  assign rxd_o = rxd_r;
  // External clock rests at idle high for polarity 0
  assign sclk_o = 1'b1;
  // Open-drain data with pull-up
  assign sda_o = sda_oe_n_i ? 1'b1 : sda_i;
endmodule : mss_remote

// ---- tb/mss_top_chk.sv ----
// Port-level checker for the serial channel top.
// Assumes it is bound into mss_top.
`timescale 1ns/1ps
module mss_top_chk (
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic PREADY_O,
  input wire logic PSLVERR_O,
  input wire logic TXD_O,
  input wire logic IRQ_O
);
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!NRST_I);
  //////////////////////////////////////////////
  sequence setup_s;
    PSEL_I && !PENABLE_I;
  endsequence
  sequence wr_s;
    PSEL_I && PENABLE_I && PREADY_O && PWRITE_I;
  endsequence
  sequence mask_off_s;
    wr_s ##0 (PADDR_I == mss_pkg::ADDR_IRQ_MASK && PWDATA_I[2:0] == 3'h0);
  endsequence
  sequence mode_off_s;
    wr_s ##0 (PADDR_I == mss_pkg::ADDR_MODE && PWDATA_I[2:0] == mss_pkg::MODE_OFF);
  endsequence
  //////////////////////////////////////////////
  chk_ready_setup: assert property (setup_s |=> PREADY_O)
    else $error("no ready after setup");
  chk_ready_pulse: assert property (PREADY_O |=> !PREADY_O)
    else $error("ready longer than one cycle");
  chk_err_unmapped: assert property (setup_s ##0 (PADDR_I > 8'h20) |=> PSLVERR_O)
    else $error("unmapped access without error");
  chk_err_mapped: assert property
    (setup_s ##0 (PADDR_I <= 8'h20 && PADDR_I[1:0] == 2'h0) |=> !PSLVERR_O)
    else $error("mapped access flagged");
  chk_rdata_zero: assert property
    (setup_s ##0 (!PWRITE_I && PADDR_I > 8'h20) |=> PRDATA_O == 32'h0)
    else $error("unmapped read not zero");
  chk_irq_masked: assert property (mask_off_s |=> ##1 !IRQ_O [*2])
    else $error("interrupt with mask cleared");
  chk_txd_reset: assert property ($rose(NRST_I) |-> TXD_O)
    else $error("serial out not idle after reset");
  chk_txd_off: assert property (mode_off_s |=> ##2 TXD_O [*2])
    else $error("serial out active while disabled");
endmodule : mss_top_chk
bind mss_top mss_top_chk mss_top_chk_i (.CLK_I(CLK_I), .NRST_I(NRST_I), .PSEL_I(PSEL_I),
  .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
  .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .TXD_O(TXD_O),
  .IRQ_O(IRQ_O));

// ---- tb/tb.sv ----
// Self-checking bench for the serial channel.
// Assumes the remote model echoes the serial line back.
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, sclk_i, sclk_o, sclk_oe_n, rxd, txd;
  logic sda_i, sda_o, sda_oe_n, irq;
  int n_errors = 0;
  int tests_run = 0;
  always #2.5 clk = ~clk;
  mss_top mss_top_i (.CLK_I(clk), .NRST_I(nrst), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .SCLK_I(sclk_i), .SCLK_O(sclk_o),
    .SCLK_OE_N_O(sclk_oe_n), .RXD_I(rxd), .TXD_O(txd), .SDA_I(sda_i), .SDA_O(sda_o),
    .SDA_OE_N_O(sda_oe_n), .IRQ_O(irq));
  mss_remote mss_remote_i (.clk_i(clk), .txd_i(txd), .sda_i(sda_o),
    .sda_oe_n_i(sda_oe_n), .rxd_o(rxd), .sclk_o(sclk_i), .sda_o(sda_i));
  //////////////////////////////////////////////
  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic hang;
    n_errors++;
    $display("[FAIL] %0t wait ran out", $time);
    summarize();
  endtask : hang
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) hang();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic poll(input logic [7:0] a, input int b);
    int k;
    for (k = 0; k < 300; k++) begin
      apb(1'b0, a, 32'h0);
      if (rd[b] === 1'b1) return;
    end
    hang();
  endtask : poll
  //////////////////////////////////////////////
  task automatic t_reset;
    apb(1'b0, mss_pkg::ADDR_CTRL_B, 32'h0);
    chk(rd[3:0], 32'h2);
    apb(1'b0, 8'h24, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    chk(txd, 1'b1);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_uart;
    logic [2:0] m [3] = '{mss_pkg::MODE_UART7, mss_pkg::MODE_UART8, mss_pkg::MODE_UART9};
    logic [8:0] e [3] = '{9'h025, 9'h0A5, 9'h1A5};
    int i;
    apb(1'b1, mss_pkg::ADDR_CTRL_A, 32'h0);
    apb(1'b1, mss_pkg::ADDR_BRG, 32'h7);
    apb(1'b1, mss_pkg::ADDR_IRQ_MASK, 32'h2);
    for (i = 0; i < 3; i++) begin
      apb(1'b1, mss_pkg::ADDR_CTRL_B, 32'h0);
      apb(1'b1, mss_pkg::ADDR_MODE, 32'(mss_pkg::MODE_OFF));
      apb(1'b1, mss_pkg::ADDR_MODE, 32'(m[i]));
      apb(1'b1, mss_pkg::ADDR_CTRL_B, 32'h5);
      apb(1'b1, mss_pkg::ADDR_TXB, 32'h1A5);
      poll(mss_pkg::ADDR_CTRL_B, mss_pkg::CB_RI);
      chk(irq, 1'b1);
      apb(1'b0, mss_pkg::ADDR_RXB, 32'h0);
      chk(rd[12:0], 32'(e[i]));
      apb(1'b0, mss_pkg::ADDR_CTRL_B, 32'h0);
      chk(rd[mss_pkg::CB_RI], 1'b0);
      apb(1'b1, mss_pkg::ADDR_IRQ_STAT, 32'h7);
    end
    $display("t_uart done");
  endtask : t_uart
  task automatic t_ovr;
    apb(1'b1, mss_pkg::ADDR_TXB, 32'h3C);
    poll(mss_pkg::ADDR_CTRL_B, mss_pkg::CB_RI);
    apb(1'b1, mss_pkg::ADDR_IRQ_MASK, 32'h0);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    apb(1'b1, mss_pkg::ADDR_IRQ_MASK, 32'h6);
    repeat (2) @(posedge clk);
    chk(irq, 1'b1);
    apb(1'b1, mss_pkg::ADDR_IRQ_STAT, 32'h7);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    apb(1'b1, mss_pkg::ADDR_TXB, 32'h5A);
    poll(mss_pkg::ADDR_IRQ_STAT, mss_pkg::IRQ_OVR);
    repeat (200) @(posedge clk);
    apb(1'b0, mss_pkg::ADDR_IRQ_STAT, 32'h0);
    chk(rd[2:1], 2'b10);
    apb(1'b0, mss_pkg::ADDR_RXB, 32'h0);
    chk(rd[mss_pkg::RB_OVR], 1'b1);
    apb(1'b1, mss_pkg::ADDR_IRQ_STAT, 32'h7);
    $display("t_ovr done");
  endtask : t_ovr
  task automatic t_sync;
    logic [7:0] v;
    logic prev;
    int n, k;
    apb(1'b1, mss_pkg::ADDR_CTRL_B, 32'h0);
    apb(1'b1, mss_pkg::ADDR_MODE, 32'(mss_pkg::MODE_OFF));
    apb(1'b1, mss_pkg::ADDR_MODE, 32'(mss_pkg::MODE_SYNC));
    apb(1'b1, mss_pkg::ADDR_CTRL_B, 32'h5);
    apb(1'b1, mss_pkg::ADDR_TXB, 32'hC6);
    v = 8'h00;
    n = 0;
    prev = sclk_o;
    for (k = 0; k < 600; k++) begin
      @(posedge clk);
      if (sclk_o === 1'b1 && prev === 1'b0) begin
        v = {txd, v[7:1]};
        n++;
      end
      prev = sclk_o;
    end
    chk(n, 8);
    chk(v, 8'hC6);
    chk({sclk_oe_n, sclk_o}, 2'b01);
    // Condition select cleared, then one shift clock before the request
    apb(1'b1, mss_pkg::ADDR_SMR4, 32'h0);
    repeat (16) @(posedge clk);
    apb(1'b1, mss_pkg::ADDR_SMR4, 32'h1);
    repeat (2) @(posedge clk);
    chk({sda_oe_n, sda_o}, 2'b00);
    apb(1'b1, mss_pkg::ADDR_SMR4, 32'h0);
    repeat (16) @(posedge clk);
    apb(1'b1, mss_pkg::ADDR_SMR4, 32'h4);
    repeat (2) @(posedge clk);
    chk({sda_oe_n, sda_o}, 2'b11);
    $display("t_sync done");
  endtask : t_sync
  //////////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge clk);
    hang();
  end
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_uart();
    t_ovr();
    t_sync();
    summarize();
  end
endmodule : tb
